// ===== hrt_core.sv
// hibernate domain: tamper clear and log, calendar match, wake sources, control handshake
`timescale 1ns/1ps
`include "hrt_consts.svh"
module hrt_core #(
  parameter int unsigned TICKS_PER_SEC = `HRT_HIB_CLK_HZ,
  parameter bit          ROUSE_PIN_FITTED = 1'b1
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // pins from the always-on side
  input  wire logic                 hib_clk_pin,
  input  wire logic [3:0]           tamper_inputs,
  input  wire logic                 rouse_pin,
  input  wire logic                 external_reset_pin,
  input  wire logic [7:4]           gpio_k,
  input  wire logic                 low_battery,
  // tamper control and log
  input  wire logic                 tamper_clear,
  input  wire logic [1:0]           tamper_log_sel,
  output logic                      tamper_pending,
  output logic                      tamper_clear_busy,
  output logic [2:0]                tamper_log_count,
  output hrt_pkg::hrt_log_entry_t   tamper_log_data,
  // power domain control and properties
  input  wire logic                 ctl_write,
  input  wire logic [7:0]           ctl_wdata,
  output logic [7:0]                power_domain_control_reg,
  output logic                      write_complete_flag,
  output logic                      rouse_pin_present_flag,
  // calendar
  input  wire logic                 twenty_four_hour_select,
  input  wire logic                 cal_load,
  input  wire logic [4:0]           cal_load_hour,
  input  wire logic [5:0]           cal_load_min,
  input  wire logic [5:0]           cal_load_sec,
  input  wire logic [4:0]           match_hour,
  input  wire logic [5:0]           match_min,
  input  wire logic [5:0]           match_sec,
  input  wire logic                 match_pm,
  output logic [4:0]                cal_hour,
  output logic [5:0]                cal_min,
  output logic [5:0]                cal_sec,
  output logic                      cal_pm,
  output logic                      cal_match,
  // wake
  input  wire logic                 hibernate_active,
  output logic                      wake_event,
  output logic [5:0]                wake_cause
);

  // hour in 12-hour form, 12 standing for midnight and noon
  function automatic logic [4:0] hrt_hour12(input logic [4:0] h24);
    logic [4:0] h;
    h = (h24 >= 5'(`HRT_HALF_DAY)) ? 5'(h24 - 5'(`HRT_HALF_DAY)) : h24;
    hrt_hour12 = (h == 5'h00) ? 5'(`HRT_HALF_DAY) : h;
  endfunction : hrt_hour12

  // two-flop synchronisers for every pin, third flop for edge detection
  logic [11:0] pin_s1_q;
  logic [11:0] pin_s2_q;
  logic [11:0] pin_s3_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_s1_q <= 12'h000;
      pin_s2_q <= 12'h000;
      pin_s3_q <= 12'h000;
    end else begin
      pin_s1_q <= {low_battery, gpio_k, external_reset_pin, rouse_pin, tamper_inputs, hib_clk_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic       hib_tick;
  logic [3:0] tamper_rise;
  logic       pin_rise;
  logic       extrst_rise;
  logic       gpio_act;
  logic       lowbat_lvl;
  assign hib_tick    = pin_s2_q[0] & ~pin_s3_q[0]; // one pulse per hibernate clock rise
  assign tamper_rise = pin_s2_q[4:1] & ~pin_s3_q[4:1];
  assign pin_rise    = pin_s2_q[5] & ~pin_s3_q[5];
  assign extrst_rise = pin_s2_q[6] & ~pin_s3_q[6];
  assign gpio_act    = |(pin_s2_q[10:7] ^ pin_s3_q[10:7]); // any toggle on the port pins
  assign lowbat_lvl  = pin_s2_q[11];

  // tamper clear sequencer: request held until three hibernate edges have passed
  hrt_pkg::hrt_clr_state_t clr_state_q;
  logic [1:0]              clr_edges_q;
  logic                    clr_done;
  assign clr_done = (clr_state_q == hrt_pkg::HRT_CLR_BUSY) && hib_tick
                    && (clr_edges_q == 2'(`HRT_TAMPER_CLR_EDGES - 1)); // R1
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      clr_state_q <= hrt_pkg::HRT_CLR_IDLE;
      clr_edges_q <= 2'h0;
    end else begin
      case (clr_state_q)
        hrt_pkg::HRT_CLR_IDLE: begin
          clr_edges_q <= 2'h0;
          if (tamper_clear) begin
            clr_state_q <= hrt_pkg::HRT_CLR_BUSY; // R12
          end
        end
        hrt_pkg::HRT_CLR_BUSY: begin
          if (clr_done) begin
            clr_state_q <= hrt_pkg::HRT_CLR_IDLE;
          end else if (hib_tick) begin
            clr_edges_q <= 2'(clr_edges_q + 2'h1); // R1
          end
        end
        default: clr_state_q <= hrt_pkg::HRT_CLR_IDLE;
      endcase
    end
  end
  assign tamper_clear_busy = (clr_state_q == hrt_pkg::HRT_CLR_BUSY);

  // events during a clear, or landing with the request, are parked: done wipes the log
  logic [3:0] held_src_q;
  logic [3:0] evt_src;
  assign evt_src = held_src_q | tamper_rise;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      held_src_q <= 4'h0;
    end else if (clr_done) begin
      held_src_q <= 4'h0;
    end else if (tamper_clear_busy || tamper_clear) begin
      held_src_q <= evt_src; // R2
    end
  end

  // pending flag: an event in the finishing cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tamper_pending <= 1'b0;
    end else if (clr_done) begin
      tamper_pending <= |evt_src; // R2
    end else if (|tamper_rise) begin
      tamper_pending <= 1'b1;
    end
  end

  // calendar counters, kept in 24-hour form internally
  logic [31:0] sub_q;
  logic [4:0]  hour_q;
  logic [5:0]  min_q;
  logic [5:0]  sec_q;
  logic        sec_step;
  assign sec_step = hib_tick && (sub_q == TICKS_PER_SEC - 1);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sub_q  <= 32'h0000_0000;
      hour_q <= 5'h00;
      min_q  <= 6'h00;
      sec_q  <= 6'h00;
    end else if (cal_load) begin
      sub_q  <= 32'h0000_0000;
      hour_q <= cal_load_hour;
      min_q  <= cal_load_min;
      sec_q  <= cal_load_sec;
    end else if (hib_tick) begin
      sub_q <= sec_step ? 32'h0000_0000 : sub_q + 32'h0000_0001;
      if (sec_step) begin
        sec_q <= (sec_q == 6'(`HRT_SEC_PER_MIN - 1)) ? 6'h00 : 6'(sec_q + 6'h01);
        if (sec_q == 6'(`HRT_SEC_PER_MIN - 1)) begin
          min_q <= (min_q == 6'(`HRT_MIN_PER_HOUR - 1)) ? 6'h00 : 6'(min_q + 6'h01);
          if (min_q == 6'(`HRT_MIN_PER_HOUR - 1)) begin
            hour_q <= (hour_q == 5'(`HRT_HOURS_PER_DAY - 1)) ? 5'h00 : 5'(hour_q + 5'h01);
          end
        end
      end
    end
  end

  // presented time follows the hour mode
  logic now_pm;
  assign now_pm = (hour_q >= 5'(`HRT_HALF_DAY));
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cal_hour <= 5'h00;
      cal_min  <= 6'h00;
      cal_sec  <= 6'h00;
      cal_pm   <= 1'b0;
    end else begin
      cal_hour <= twenty_four_hour_select ? hour_q : hrt_hour12(hour_q); // R5
      cal_min  <= min_q;
      cal_sec  <= sec_q;
      cal_pm   <= now_pm; // R7
    end
  end

  // match: am/pm qualifies the hour in 12-hour mode, so only one hit a day
  logic equal_now;
  logic equal_q;
  assign equal_now = (min_q == match_min) && (sec_q == match_sec)
                     && (twenty_four_hour_select ? (hour_q == match_hour)
                         : ((hrt_hour12(hour_q) == match_hour) && (now_pm == match_pm))); // R6
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      equal_q   <= 1'b0;
      cal_match <= 1'b0;
    end else begin
      equal_q   <= equal_now;
      cal_match <= equal_now & ~equal_q; // one pulse on entering the match second
    end
  end

  // tamper log: first three entries stick, the last slot takes the latest
  hrt_pkg::hrt_log_entry_t log_q [`HRT_LOG_DEPTH];
  hrt_pkg::hrt_log_entry_t new_entry;
  logic [1:0]              wr_idx;
  assign new_entry = {evt_src, hour_q, min_q, sec_q};
  assign wr_idx = (tamper_log_count >= 3'(`HRT_LOG_FIRST_KEPT)) ? 2'h3 : tamper_log_count[1:0];
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tamper_log_count <= 3'h0;
      for (int i = 0; i < `HRT_LOG_DEPTH; i++) begin
        log_q[i] <= 21'h000000;
      end
    end else if (clr_done) begin
      for (int i = 0; i < `HRT_LOG_DEPTH; i++) begin
        log_q[i] <= 21'h000000; // R2
      end
      log_q[0]         <= (|evt_src) ? new_entry : 21'h000000;
      tamper_log_count <= (|evt_src) ? 3'h1 : 3'h0;
    end else if (!tamper_clear_busy && (|tamper_rise)) begin
      log_q[wr_idx] <= new_entry; // R11
      if (tamper_log_count < 3'(`HRT_LOG_DEPTH)) begin
        tamper_log_count <= 3'(tamper_log_count + 3'h1);
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tamper_log_data <= 21'h000000;
    end else begin
      tamper_log_data <= log_q[tamper_log_sel];
    end
  end

  // control write handshake: data parked until the next hibernate edge
  logic       ctl_pend_q;
  logic [7:0] ctl_hold_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctl_pend_q               <= 1'b0;
      ctl_hold_q               <= `HRT_CTL_RESET;
      power_domain_control_reg <= `HRT_CTL_RESET;
      write_complete_flag      <= 1'b0;
    end else if (ctl_write) begin
      ctl_pend_q          <= 1'b1; // R12
      ctl_hold_q          <= ctl_wdata;
      write_complete_flag <= 1'b0;
    end else if (ctl_pend_q && hib_tick) begin
      ctl_pend_q               <= 1'b0;
      power_domain_control_reg <= ctl_hold_q;
      write_complete_flag      <= 1'b1; // R8
    end
  end

  // strap-like property, caught by a clocked process
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rouse_pin_present_flag <= 1'b0;
    end else begin
      rouse_pin_present_flag <= ROUSE_PIN_FITTED; // R3
    end
  end

  // wake sources, each gated by its enable bit in the control register
  logic [5:0] cause_now;
  assign cause_now = {
    power_domain_control_reg[`HRT_EN_TAMPER] & (|tamper_rise),
    power_domain_control_reg[`HRT_EN_GPIO]   & gpio_act,
    power_domain_control_reg[`HRT_EN_EXTRST] & extrst_rise,
    power_domain_control_reg[`HRT_EN_PIN]    & pin_rise & rouse_pin_present_flag, // R3
    power_domain_control_reg[`HRT_EN_LOWBAT] & lowbat_lvl,
    power_domain_control_reg[`HRT_EN_RTC]    & cal_match
  }; // R4
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wake_event <= 1'b0;
      wake_cause <= 6'h00;
    end else begin
      wake_event <= hibernate_active && (|cause_now); // R4
      if (hibernate_active && (|cause_now)) begin
        wake_cause <= cause_now;
      end
    end
  end

endmodule : hrt_core

// ===== hrt_consts.svh
// constants of the hibernate rtc and tamper block
// Summary of operation
// R1: setting tamper_clear clears the pending tamper event after three hibernate clock edges.
// R2: a finished clear empties the log; events during clear are held, then logged.
// R3: rouse_pin_present_flag shows the wake pin exists; the pin then wakes the device.
// R4: wake on rtc match, low battery, external reset, gpio K[7:4] or tamper inputs.
// R5: twenty_four_hour_select clear gives 12-hour form with am/pm, set gives 24-hour.
// R6: in 12-hour mode the match also compares am/pm, one match per day.
// R7: calendar time presents the current am/pm state as a readable bit.
// R8: write_complete_flag rises once a control write lands, also the first after reset.
// R9: software waits for write_complete_flag, else resets the module and rewrites; the bench fails the check and ends the run instead.
// R10: software rewrites control when the flag is set but the value is wrong.
// R11: the tamper log keeps four entries: first three events and the latest.
// R12: system-side requests act on hibernate clock edges and report back completion.
`ifndef HRT_CONSTS_SVH
`define HRT_CONSTS_SVH
`define HRT_HIB_CLK_HZ        32768
`define HRT_TAMPER_CLR_EDGES  3
`define HRT_LOG_DEPTH         4
`define HRT_LOG_FIRST_KEPT    3
`define HRT_CTL_W             8
`define HRT_CTL_RESET         8'h00
`define HRT_EN_RTC            0
`define HRT_EN_LOWBAT         1
`define HRT_EN_PIN            2
`define HRT_EN_EXTRST         3
`define HRT_EN_GPIO           4
`define HRT_EN_TAMPER         5
`define HRT_HOURS_PER_DAY     24
`define HRT_HALF_DAY          12
`define HRT_MIN_PER_HOUR      60
`define HRT_SEC_PER_MIN       60
`endif

// ===== hrt_pkg.sv
// types of the hibernate rtc and tamper block
package hrt_pkg;
  typedef enum logic [1:0] {
    HRT_CLR_IDLE  = 2'b00,
    HRT_CLR_BUSY  = 2'b01
  } hrt_clr_state_t;
  // log entry: tamper sources, hour (24h), minute, second
  typedef logic [20:0] hrt_log_entry_t;
endpackage : hrt_pkg

// ===== hrt_core_properties.sv
// port assertions of the hibernate rtc and tamper core
`timescale 1ns/1ps
module hrt_chk #(
  parameter bit ROUSE_PIN_FITTED = 1'b1
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // tamper
  input wire logic       tamper_clear,
  input wire logic       tamper_clear_busy,
  input wire logic [2:0] tamper_log_count,
  // control, wake, calendar
  input wire logic       ctl_write,
  input wire logic       write_complete_flag,
  input wire logic       rouse_pin_present_flag,
  input wire logic       hibernate_active,
  input wire logic       wake_event,
  input wire logic       cal_match
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a clear is taken only when idle
  sequence clr_taken;
    tamper_clear && !tamper_clear_busy;
  endsequence
  // three hib ticks span well over eight system cycles, but end in bounded time
  sequence clr_runs;
    tamper_clear_busy [*8] ##[1:60] !tamper_clear_busy;
  endsequence
  a_clr_runs: assert property (clr_taken |=> clr_runs)
    else $error("tamper clear length wrong");
  a_clr_empties_log: assert property ($fell(tamper_clear_busy) |-> tamper_log_count <= 3'h1)
    else $error("log not emptied by clear");
  a_log_bound: assert property (tamper_log_count <= 3'h4)
    else $error("log count above four");
  a_rouse_flag: assert property ($past(rst_b) |-> rouse_pin_present_flag == ROUSE_PIN_FITTED)
    else $error("wake pin presence flag wrong");
  a_wc_drops: assert property (ctl_write |=> !write_complete_flag)
    else $error("write complete not cleared by write");
  a_wc_returns: assert property (ctl_write |-> ##[2:40] write_complete_flag)
    else $error("write complete never returned");
  a_wake_gated: assert property (wake_event |-> $past(hibernate_active))
    else $error("wake outside hibernate");
  a_match_pulse: assert property (cal_match |=> !cal_match)
    else $error("calendar match longer than a pulse");
endmodule : hrt_chk
bind hrt_core hrt_chk #(.ROUSE_PIN_FITTED(ROUSE_PIN_FITTED)) i_hrt_chk (.clk_sys, .rst_b,
  .tamper_clear, .tamper_clear_busy, .tamper_log_count, .ctl_write, .write_complete_flag,
  .rouse_pin_present_flag, .hibernate_active, .wake_event, .cal_match);

// ===== hrt_pins_model.sv
// far side pins: free running hibernate clock and tamper switches
`timescale 1ns/1ps
module hrt_pins #(
  parameter int HALF = 4
) (
  // system clock
  input  wire logic       clk_sys,
  // switch request from the bench
  input  wire logic [3:0] fire,
  // pins
  output logic            hib_clk_pin,
  output logic [3:0]      tamper_inputs
);
  int div_q;
  int hold_q;
  initial begin
    hib_clk_pin = 0;
    tamper_inputs = 0;
    div_q = 0;
    hold_q = 0;
  end
  // the crystal runs free, shortened to 8 system cycles a period
  always @(posedge clk_sys) begin
    div_q <= (div_q == HALF - 1) ? 0 : div_q + 1;
    if (div_q == HALF - 1) hib_clk_pin <= ~hib_clk_pin;
  end
  // a closure stays up long enough to pass the input synchronisers
  always @(posedge clk_sys) begin
    if (fire != 0) begin
      tamper_inputs <= fire;
      hold_q <= 6;
    end else if (hold_q != 0) hold_q <= hold_q - 1;
    else tamper_inputs <= 0;
  end
endmodule : hrt_pins

// ===== hrt_core_tb.sv
// self-checking bench of the hibernate rtc and tamper core
`timescale 1ns/1ps
module hrt_core_tb;
  logic clk_sys, rst_b, hib_clk_pin, rouse_pin, external_reset_pin, low_battery;
  logic tamper_clear, tamper_pending, tamper_clear_busy, ctl_write, write_complete_flag;
  logic rouse_pin_present_flag, twenty_four_hour_select, cal_load, match_pm, cal_pm;
  logic cal_match, hibernate_active, wake_event;
  logic [3:0] tamper_inputs, fire;
  logic [7:4] gpio_k;
  logic [1:0] tamper_log_sel;
  logic [2:0] tamper_log_count;
  logic [7:0] ctl_wdata, power_domain_control_reg, seed;
  logic [4:0] cal_load_hour, match_hour, cal_hour;
  logic [5:0] cal_load_min, cal_load_sec, match_min, match_sec, cal_min, cal_sec, wake_cause;
  hrt_pkg::hrt_log_entry_t tamper_log_data;
  logic [3:0] evs [5] = '{4'h1, 4'h2, 4'h4, 4'h2, 4'h8};
  int n_fail, comparisons, i, k, n;
  hrt_pins i_hrt_pins (.clk_sys, .fire, .hib_clk_pin, .tamper_inputs);
  // four ticks a second keeps calendar runs short
  hrt_core #(.TICKS_PER_SEC(4)) i_hrt_core (.clk_sys, .rst_b, .hib_clk_pin, .tamper_inputs,
    .rouse_pin, .external_reset_pin, .gpio_k, .low_battery, .tamper_clear, .tamper_log_sel,
    .tamper_pending, .tamper_clear_busy, .tamper_log_count, .tamper_log_data, .ctl_write,
    .ctl_wdata, .power_domain_control_reg, .write_complete_flag, .rouse_pin_present_flag,
    .twenty_four_hour_select, .cal_load, .cal_load_hour, .cal_load_min, .cal_load_sec,
    .match_hour, .match_min, .match_sec, .match_pm, .cal_hour, .cal_min, .cal_sec, .cal_pm,
    .cal_match, .hibernate_active, .wake_event, .wake_cause);
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // a wait that ran out ends the run at once
  task automatic bound(input logic ok, input string what);
    if (ok !== 1'b1) begin
      chk(what, 0, 1);
      wrap_up();
    end
  endtask : bound
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic tmp(input logic [3:0] v);
    @(posedge clk_sys) fire <= v;
    @(posedge clk_sys) fire <= 0;
  endtask : tmp
  // write control, and write again while the landed value differs
  task automatic ctl_wr(input logic [7:0] d);
    for (k = 0; k < 3; k++) begin
      @(posedge clk_sys) begin ctl_write <= 1; ctl_wdata <= d; end
      @(posedge clk_sys) ctl_write <= 0;
      cyc(1);
      for (i = 0; i < 60 && write_complete_flag !== 1'b1; i++) cyc(1);
      bound(write_complete_flag, "write_complete_flag");
      if (power_domain_control_reg === d) break;
    end
  endtask : ctl_wr
  task automatic log_src(input logic [1:0] s, input logic [3:0] e);
    @(posedge clk_sys) tamper_log_sel <= s;
    cyc(2);
    chk("tamper_log_src", tamper_log_data[20:17], e);
  endtask : log_src
  // clear, with an optional event landing inside the clear window
  task automatic clr(input logic [3:0] during);
    @(posedge clk_sys) tamper_clear <= 1;
    @(posedge clk_sys) tamper_clear <= 0;
    if (during != 0) tmp(during);
    cyc(1);
    for (i = 0; i < 80 && tamper_clear_busy !== 1'b0; i++) cyc(1);
    bound(!tamper_clear_busy, "tamper_clear_busy");
  endtask : clr
  // hour as shown in the selected form, 12 standing for noon and midnight
  function automatic logic [4:0] hour_shown(input logic [4:0] h);
    if (twenty_four_hour_select) return h;
    if (h == 5'h00) return 5'h0C;
    return (h > 5'h0C) ? 5'(h - 5'h0C) : h;
  endfunction : hour_shown
  // the match pulse comes one edge after the load lands, so counting starts there
  task automatic cal_run(input logic [4:0] h, input logic pm);
    @(posedge clk_sys) begin cal_load <= 1; cal_load_hour <= h; end
    @(posedge clk_sys) cal_load <= 0;
    cyc(1);
    chk("cal_pm", cal_pm, pm);
    chk("cal_time", {cal_hour, cal_min, cal_sec}, {hour_shown(h), 6'h3B, 6'h3B});
    n = cal_match;
    for (i = 1; i < 100; i++) begin cyc(1); n += cal_match; end
    chk("cal_match_count", n, pm);
  endtask : cal_run
  initial begin
    {rst_b, rouse_pin, external_reset_pin, low_battery, tamper_clear, ctl_write} = '0;
    {twenty_four_hour_select, cal_load, hibernate_active, fire, gpio_k} = '0;
    {tamper_log_sel, ctl_wdata, cal_load_hour, match_hour} = '0;
    {cal_load_min, cal_load_sec, match_min, match_sec, match_pm} = {24'hEFBEFB, 1'b1};
    n_fail = 0;
    comparisons = 0;
    seed = 8'h4F;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1;
    cyc(3);
    chk("rouse_pin_present_flag", rouse_pin_present_flag, 1);
    chk("tamper_log_count", tamper_log_count, 0);
    // random control values, the first straight after reset
    repeat (4) begin
      seed = lfsr(seed);
      ctl_wr(seed);
      chk("power_domain_control_reg", power_domain_control_reg, seed);
    end
    // five events overflow the four entry log
    foreach (evs[j]) begin tmp(evs[j]); cyc(10); end
    chk("tamper_log_count", tamper_log_count, 4);
    log_src(0, 4'h1);
    log_src(2, 4'h4);
    log_src(3, 4'h8);
    clr(4'h2);
    chk("tamper_log_count", tamper_log_count, 1);
    chk("tamper_pending", tamper_pending, 1);
    log_src(0, 4'h2);
    clr(4'h0);
    chk("tamper_log_count", tamper_log_count, 0);
    chk("tamper_pending", tamper_pending, 0);
    // a morning time must not match an afternoon match in either form
    for (k = 0; k < 2; k++) begin
      @(posedge clk_sys) begin twenty_four_hour_select <= k[0]; match_hour <= k ? 5'h17 : 5'h0B; end
      cal_run(5'h0B, 0);
      cal_run(5'h17, 1);
    end
    @(posedge clk_sys) hibernate_active <= 1;
    ctl_wr(8'h3F);
    for (k = 1; k < 6; k++) begin
      @(posedge clk_sys) case (k)
        1: low_battery <= 1;
        2: rouse_pin <= 1;
        3: external_reset_pin <= 1;
        4: gpio_k <= 4'h5;
        default: fire <= 4'h4;
      endcase
      @(posedge clk_sys) begin low_battery <= 0; fire <= 0; end
      for (i = 0; i < 20 && wake_event !== 1'b1; i++) cyc(1);
      bound(wake_event, "wake_event");
      chk("wake_cause", wake_cause, 6'h01 << k);
      cyc(20);
    end
    wrap_up();
  end
endmodule : hrt_core_tb
